/* File: common/rx_perf_pkg.sv */
package rx_perf_pkg;

  // ****************************************
  // widths and reset values
  // ****************************************
  localparam int          NUM_CH   = 4;
  localparam int          CNT_W    = 16;
  localparam int          LBL_W    = 3;
  localparam int          REG_W    = 16;
  localparam int          DATA_W   = 32;
  localparam int          ADDR_W   = 12;
  localparam int          IDX_W    = 8;
  localparam int          IDX_LSB  = 2;
  localparam logic [15:0] CNT_RST  = 16'hFFFC;
  localparam logic [2:0]  LBL_RST  = 3'h6;

  // ****************************************
  // register indices (byte address = 4 * index)
  // ****************************************
  localparam logic [7:0] IDX_ASSIGNED_CH3 = 8'h20;
  localparam logic [7:0] IDX_ASSIGNED_CH2 = 8'h21;
  localparam logic [7:0] IDX_ASSIGNED_CH1 = 8'h22;
  localparam logic [7:0] IDX_ASSIGNED_CH0 = 8'h23;
  localparam logic [7:0] IDX_IDLE_CH3     = 8'h24;
  localparam logic [7:0] IDX_IDLE_CH2     = 8'h25;
  localparam logic [7:0] IDX_IDLE_CH1     = 8'h26;
  localparam logic [7:0] IDX_IDLE_CH0     = 8'h27;
  localparam logic [7:0] IDX_DROPPED_CH3  = 8'h28;
  localparam logic [7:0] IDX_DROPPED_CH2  = 8'h29;
  localparam logic [7:0] IDX_DROPPED_CH1  = 8'h2A;
  localparam logic [7:0] IDX_DROPPED_CH0  = 8'h2B;
  localparam logic [7:0] IDX_LABEL_P3     = 8'h2C;
  localparam logic [7:0] IDX_LABEL_P2     = 8'h2D;
  localparam logic [7:0] IDX_LABEL_P1     = 8'h2E;
  localparam logic [7:0] IDX_LABEL_P0     = 8'h2F;
  localparam logic [7:0] IDX_ROLL_ERR     = 8'h53;
  localparam logic [7:0] IDX_ROLL_CELL    = 8'h55;
  localparam logic [7:0] IDX_ROLL_CELL_CLR = 8'h56;
  localparam logic [7:0] IDX_ROLL_CELL_EN  = 8'h57;
  localparam logic [7:0] IDX_ROLL_ERR_CLR  = 8'h58;
  localparam logic [7:0] IDX_ROLL_ERR_EN   = 8'h59;
  localparam logic [7:0] IDX_LINE_MODE     = 8'h5A;

  // ****************************************
  // rollover bit positions, channel k at lsb + k
  // ****************************************
  localparam int ROLL_CELL_IDLE_LSB     = 0;
  localparam int ROLL_CELL_ASSIGNED_LSB = 4;
  localparam int ROLL_ERR_DROPPED_LSB   = 1;
  localparam int ROLL_ERR_LABEL_LSB     = 9;
  localparam int LINE_MODE_BIT          = 0;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic {MODE_FOUR_CH, MODE_CONCAT} line_mode_t;

endpackage

/* File: src/wrap_counter.sv */
`timescale 1ns/100ps
module wrap_counter
  import rx_perf_pkg::*;
#(
  parameter int             W    = 16,
  parameter logic [W-1:0]   INIT = '0
)(
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic         inc,
  output logic [W-1:0]      count,
  output logic              wrap
);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      count <= INIT;
    else if (inc)
      count <= count + W'(1);
  end

  // pulse on the event that takes the count from all ones back to zero
  assign wrap = inc & (&count);

endmodule // wrap_counter

/* File: src/axil_slave.sv */
`timescale 1ns/100ps
module axil_slave
  import rx_perf_pkg::*;
(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [DATA_W-1:0] wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [DATA_W-1:0]      rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  output logic                   wr_en,
  output logic [IDX_W-1:0]       wr_idx,
  output logic [DATA_W-1:0]      wr_data,
  output logic [DATA_W-1:0]      wr_mask,
  input  wire logic              wr_ok,
  output logic [IDX_W-1:0]       rd_idx,
  input  wire logic [DATA_W-1:0] rd_data,
  input  wire logic              rd_ok
);

  logic              aw_full_reg;
  logic              w_full_reg;
  logic [IDX_W-1:0]  aw_idx_reg;
  logic [3:0]        w_strb_reg;

  // address and data are taken in either order and held until both are in
  assign awready = ~aw_full_reg & ~bvalid;
  assign wready  = ~w_full_reg & ~bvalid;
  assign wr_en   = aw_full_reg & w_full_reg & ~bvalid;
  assign wr_idx  = aw_idx_reg;
  assign arready = ~rvalid;
  assign rd_idx  = araddr[IDX_W+IDX_LSB-1:IDX_LSB];

  generate
    for (genvar b = 0; b < 4; b++)
    begin : g_mask
      assign wr_mask[8*b+7:8*b] = {8{w_strb_reg[b]}};
    end
  endgenerate

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_full_reg <= 1'b0;
      aw_idx_reg  <= '0;
    end
    else if (awvalid && awready)
    begin
      aw_full_reg <= 1'b1;
      aw_idx_reg  <= awaddr[IDX_W+IDX_LSB-1:IDX_LSB];
    end
    else if (wr_en)
      aw_full_reg <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      w_full_reg <= 1'b0;
      wr_data    <= '0;
      w_strb_reg <= '0;
    end
    else if (wvalid && wready)
    begin
      w_full_reg <= 1'b1;
      wr_data    <= wdata;
      w_strb_reg <= wstrb;
    end
    else if (wr_en)
      w_full_reg <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid <= 1'b0;
      bresp  <= RESP_OKAY;
    end
    else if (wr_en)
    begin
      bvalid <= 1'b1;
      bresp  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
    end
    else if (bready)
      bvalid <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid <= 1'b0;
      rdata  <= '0;
      rresp  <= RESP_OKAY;
    end
    else if (arvalid && arready)
    begin
      rvalid <= 1'b1;
      rdata  <= rd_ok ? rd_data : '0;
      rresp  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end
    else if (rready)
      rvalid <= 1'b0;
  end

endmodule // axil_slave

/* File: src/rx_cell_perf_counters.sv */
// Behaviour
// - each channel counts received assigned cells in 16 bits, wrapping to zero.
// - channel 0 assigned-count wrap sets bit 4 of rollover register 0x55.
// - channels 3,2,1 assigned-count wraps set bits 7,6,5 of 0x55.
// - each channel counts received idle cells in 16 bits, wrapping to zero.
// - idle-count wraps of channels 3..0 set bits 3..0 of 0x55.
// - in sync state, cells with multi-bit header errors are dropped and counted.
// - the drop count holds while that channel's cell delineation is lost.
// - drop-count wraps of channels 3..0 set bits 4..1 of 0x53.
// - each payload counts C2 signal label mismatches in a 3-bit field.
// - mismatch count freezes on LOS, LOF, LCD, LOP, path AIS or OOF.
// - the mismatch count wraps to zero after seven.
// - mismatch-count wraps of payloads 3..0 set bits 12..9 of 0x53.
// - channel 0 counts in both line modes; channels 1-3 only in four-channel mode.
// - cell counters reset to 0xFFFC and ignore host writes.
// - mismatch registers reset to 0x0006, upper bits read zero.
`timescale 1ns/100ps
module rx_cell_perf_counters
  import rx_perf_pkg::*;
(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // ****************************************
  // register bus
  // ****************************************
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [DATA_W-1:0] s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [DATA_W-1:0]      s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // ****************************************
  // event strobes and sync/delineation levels from the cell processors, bit k = channel k
  // ****************************************
  input  wire logic [NUM_CH-1:0] assigned_cell_stb,
  input  wire logic [NUM_CH-1:0] idle_cell_stb,
  input  wire logic [NUM_CH-1:0] hdr_multi_err_stb,
  input  wire logic [NUM_CH-1:0] cell_sync,
  input  wire logic [NUM_CH-1:0] cell_delin_lost,
  // ****************************************
  // framer path label checks and defects
  // ****************************************
  input  wire logic [NUM_CH-1:0] label_miss_stb,
  input  wire logic              loss_of_signal,
  input  wire logic              loss_of_frame,
  input  wire logic              out_of_frame,
  input  wire logic [NUM_CH-1:0] loss_of_pointer,
  input  wire logic [NUM_CH-1:0] path_ais,
  output logic                   irq
);

  // ****************************************
  // declarations
  // ****************************************
  logic [CNT_W-1:0]  assigned_cnt [NUM_CH];
  logic [CNT_W-1:0]  idle_cnt     [NUM_CH];
  logic [CNT_W-1:0]  dropped_cnt  [NUM_CH];
  logic [LBL_W-1:0]  label_cnt    [NUM_CH];
  logic [NUM_CH-1:0] ch_active;
  logic [NUM_CH-1:0] assigned_inc;
  logic [NUM_CH-1:0] idle_inc;
  logic [NUM_CH-1:0] dropped_inc;
  logic [NUM_CH-1:0] label_inc;
  logic [NUM_CH-1:0] label_frozen;
  logic [NUM_CH-1:0] assigned_wrap;
  logic [NUM_CH-1:0] idle_wrap;
  logic [NUM_CH-1:0] dropped_wrap;
  logic [NUM_CH-1:0] label_wrap;
  logic [REG_W-1:0]  roll_cell_reg;
  logic [REG_W-1:0]  roll_err_reg;
  logic [REG_W-1:0]  roll_cell_set;
  logic [REG_W-1:0]  roll_err_set;
  logic [REG_W-1:0]  roll_cell_clr;
  logic [REG_W-1:0]  roll_err_clr;
  logic [REG_W-1:0]  roll_cell_en_reg;
  logic [REG_W-1:0]  roll_err_en_reg;
  logic [REG_W-1:0]  wr_data16;
  logic [REG_W-1:0]  wr_mask16;
  line_mode_t        line_mode_reg;
  logic              wr_en;
  logic [IDX_W-1:0]  wr_idx;
  logic [DATA_W-1:0] wr_data;
  logic [DATA_W-1:0] wr_mask;
  logic              wr_ok;
  logic [IDX_W-1:0]  rd_idx;
  logic [DATA_W-1:0] rd_data;
  logic              rd_ok;

  // ****************************************
  // bus slave
  // ****************************************
  axil_slave u_bus
  (
    .aclk    (aclk),
    .aresetn (aresetn),
    .awaddr  (s_axi_awaddr),
    .awvalid (s_axi_awvalid),
    .awready (s_axi_awready),
    .wdata   (s_axi_wdata),
    .wstrb   (s_axi_wstrb),
    .wvalid  (s_axi_wvalid),
    .wready  (s_axi_wready),
    .bresp   (s_axi_bresp),
    .bvalid  (s_axi_bvalid),
    .bready  (s_axi_bready),
    .araddr  (s_axi_araddr),
    .arvalid (s_axi_arvalid),
    .arready (s_axi_arready),
    .rdata   (s_axi_rdata),
    .rresp   (s_axi_rresp),
    .rvalid  (s_axi_rvalid),
    .rready  (s_axi_rready),
    .wr_en   (wr_en),
    .wr_idx  (wr_idx),
    .wr_data (wr_data),
    .wr_mask (wr_mask),
    .wr_ok   (wr_ok),
    .rd_idx  (rd_idx),
    .rd_data (rd_data),
    .rd_ok   (rd_ok)
  );

  assign wr_data16 = wr_data[REG_W-1:0];
  assign wr_mask16 = wr_mask[REG_W-1:0];

  // ****************************************
  // per-channel counters
  // ****************************************
  generate
    for (genvar k = 0; k < NUM_CH; k++)
    begin : g_ch
      // in concatenated mode only channel 0 carries traffic, so the others hold
      assign ch_active[k]    = (k == 0) || (line_mode_reg == MODE_FOUR_CH);
      assign assigned_inc[k] = ch_active[k] & assigned_cell_stb[k];
      assign idle_inc[k]     = ch_active[k] & idle_cell_stb[k];
      assign dropped_inc[k]  = ch_active[k] & hdr_multi_err_stb[k] & cell_sync[k]
                               & ~cell_delin_lost[k];
      // C2 is not trusted while any of these defects stands
      assign label_frozen[k] = loss_of_signal | loss_of_frame | out_of_frame
                               | cell_delin_lost[k] | loss_of_pointer[k] | path_ais[k];
      assign label_inc[k]    = ch_active[k] & label_miss_stb[k] & ~label_frozen[k];

      wrap_counter #(.W(CNT_W), .INIT(CNT_RST)) u_assigned
      (
        .aclk    (aclk),
        .aresetn (aresetn),
        .inc     (assigned_inc[k]),
        .count   (assigned_cnt[k]),
        .wrap    (assigned_wrap[k])
      );

      wrap_counter #(.W(CNT_W), .INIT(CNT_RST)) u_idle
      (
        .aclk    (aclk),
        .aresetn (aresetn),
        .inc     (idle_inc[k]),
        .count   (idle_cnt[k]),
        .wrap    (idle_wrap[k])
      );

      wrap_counter #(.W(CNT_W), .INIT(CNT_RST)) u_dropped
      (
        .aclk    (aclk),
        .aresetn (aresetn),
        .inc     (dropped_inc[k]),
        .count   (dropped_cnt[k]),
        .wrap    (dropped_wrap[k])
      );

      wrap_counter #(.W(LBL_W), .INIT(LBL_RST)) u_label
      (
        .aclk    (aclk),
        .aresetn (aresetn),
        .inc     (label_inc[k]),
        .count   (label_cnt[k]),
        .wrap    (label_wrap[k])
      );
    end
  endgenerate

  // ****************************************
  // rollover status
  // ****************************************
  always_comb
  begin
    roll_cell_set = '0;
    roll_err_set  = '0;
    for (int k = 0; k < NUM_CH; k++)
    begin
      roll_cell_set[ROLL_CELL_IDLE_LSB + k]     = idle_wrap[k];
      roll_cell_set[ROLL_CELL_ASSIGNED_LSB + k] = assigned_wrap[k];
      roll_err_set[ROLL_ERR_DROPPED_LSB + k]    = dropped_wrap[k];
      roll_err_set[ROLL_ERR_LABEL_LSB + k]      = label_wrap[k];
    end
  end

  assign roll_cell_clr = (wr_en && wr_idx == IDX_ROLL_CELL_CLR) ? (wr_data16 & wr_mask16) : '0;
  assign roll_err_clr  = (wr_en && wr_idx == IDX_ROLL_ERR_CLR) ? (wr_data16 & wr_mask16) : '0;

  // a wrap in the same cycle as its clear is kept
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      roll_cell_reg <= '0;
    else
      roll_cell_reg <= (roll_cell_reg & ~roll_cell_clr) | roll_cell_set;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      roll_err_reg <= '0;
    else
      roll_err_reg <= (roll_err_reg & ~roll_err_clr) | roll_err_set;
  end

  // ****************************************
  // control registers
  // ****************************************
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      roll_cell_en_reg <= '0;
      roll_err_en_reg  <= '0;
    end
    else if (wr_en)
    begin
      if (wr_idx == IDX_ROLL_CELL_EN)
        roll_cell_en_reg <= (roll_cell_en_reg & ~wr_mask16) | (wr_data16 & wr_mask16);
      if (wr_idx == IDX_ROLL_ERR_EN)
        roll_err_en_reg <= (roll_err_en_reg & ~wr_mask16) | (wr_data16 & wr_mask16);
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      line_mode_reg <= MODE_FOUR_CH;
    else if (wr_en && wr_idx == IDX_LINE_MODE && wr_mask[LINE_MODE_BIT])
      line_mode_reg <= line_mode_t'(wr_data[LINE_MODE_BIT]);
  end

  assign irq = (|(roll_cell_reg & roll_cell_en_reg)) | (|(roll_err_reg & roll_err_en_reg));

  // ****************************************
  // write decode
  // ****************************************
  // counter and status writes are accepted but change nothing
  always_comb
  begin
    case (wr_idx)
      IDX_ASSIGNED_CH3, IDX_ASSIGNED_CH2, IDX_ASSIGNED_CH1, IDX_ASSIGNED_CH0,
      IDX_IDLE_CH3, IDX_IDLE_CH2, IDX_IDLE_CH1, IDX_IDLE_CH0,
      IDX_DROPPED_CH3, IDX_DROPPED_CH2, IDX_DROPPED_CH1, IDX_DROPPED_CH0,
      IDX_LABEL_P3, IDX_LABEL_P2, IDX_LABEL_P1, IDX_LABEL_P0,
      IDX_ROLL_CELL, IDX_ROLL_ERR,
      IDX_ROLL_CELL_CLR, IDX_ROLL_ERR_CLR, IDX_ROLL_CELL_EN, IDX_ROLL_ERR_EN,
      IDX_LINE_MODE:
        wr_ok = 1'b1;
      default:
        wr_ok = 1'b0;
    endcase
  end

  // ****************************************
  // read decode
  // ****************************************
  always_comb
  begin
    rd_data = '0;
    rd_ok   = 1'b1;
    case (rd_idx)
      IDX_ASSIGNED_CH3:  rd_data[CNT_W-1:0] = assigned_cnt[3];
      IDX_ASSIGNED_CH2:  rd_data[CNT_W-1:0] = assigned_cnt[2];
      IDX_ASSIGNED_CH1:  rd_data[CNT_W-1:0] = assigned_cnt[1];
      IDX_ASSIGNED_CH0:  rd_data[CNT_W-1:0] = assigned_cnt[0];
      IDX_IDLE_CH3:      rd_data[CNT_W-1:0] = idle_cnt[3];
      IDX_IDLE_CH2:      rd_data[CNT_W-1:0] = idle_cnt[2];
      IDX_IDLE_CH1:      rd_data[CNT_W-1:0] = idle_cnt[1];
      IDX_IDLE_CH0:      rd_data[CNT_W-1:0] = idle_cnt[0];
      IDX_DROPPED_CH3:   rd_data[CNT_W-1:0] = dropped_cnt[3];
      IDX_DROPPED_CH2:   rd_data[CNT_W-1:0] = dropped_cnt[2];
      IDX_DROPPED_CH1:   rd_data[CNT_W-1:0] = dropped_cnt[1];
      IDX_DROPPED_CH0:   rd_data[CNT_W-1:0] = dropped_cnt[0];
      IDX_LABEL_P3:      rd_data[LBL_W-1:0] = label_cnt[3];
      IDX_LABEL_P2:      rd_data[LBL_W-1:0] = label_cnt[2];
      IDX_LABEL_P1:      rd_data[LBL_W-1:0] = label_cnt[1];
      IDX_LABEL_P0:      rd_data[LBL_W-1:0] = label_cnt[0];
      IDX_ROLL_CELL:     rd_data[REG_W-1:0] = roll_cell_reg;
      IDX_ROLL_ERR:      rd_data[REG_W-1:0] = roll_err_reg;
      IDX_ROLL_CELL_EN:  rd_data[REG_W-1:0] = roll_cell_en_reg;
      IDX_ROLL_ERR_EN:   rd_data[REG_W-1:0] = roll_err_en_reg;
      IDX_ROLL_CELL_CLR: rd_data = '0;
      IDX_ROLL_ERR_CLR:  rd_data = '0;
      IDX_LINE_MODE:     rd_data[LINE_MODE_BIT] = (line_mode_reg == MODE_CONCAT);
      default:           rd_ok = 1'b0;
    endcase
  end

endmodule // rx_cell_perf_counters

/* File: dv/rx_perf_assertions.sv */
`timescale 1ns/100ps
module rx_perf_assertions
  import rx_perf_pkg::*;
(
  input wire logic              aclk,
  input wire logic              aresetn,
  input wire logic              s_axi_awvalid,
  input wire logic              s_axi_awready,
  input wire logic              s_axi_wvalid,
  input wire logic              s_axi_wready,
  input wire logic [1:0]        s_axi_bresp,
  input wire logic              s_axi_bvalid,
  input wire logic              s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic              s_axi_arvalid,
  input wire logic              s_axi_arready,
  input wire logic [DATA_W-1:0] s_axi_rdata,
  input wire logic [1:0]        s_axi_rresp,
  input wire logic              s_axi_rvalid,
  input wire logic              s_axi_rready,
  input wire logic              irq
);
  // ****************************************
  // bus handshake and register read checks
  // ****************************************
  default clocking dc @(posedge aclk); endclocking
  default disable iff (!aresetn);

  logic ar_take;
  assign ar_take = s_axi_arvalid && s_axi_arready;

  a_read_latency: assert property (ar_take |=> s_axi_rvalid)
    else $error("read answer not one cycle after address");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before taken");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before taken");
  a_write_latency: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |=> !s_axi_bvalid ##1 s_axi_bvalid)
    else $error("write response timing wrong");
  a_read_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("address accepted while read pending");
  a_write_block: assert property (s_axi_bvalid |-> !(s_axi_awready || s_axi_wready))
    else $error("write accepted while response pending");
  a_unmapped_err: assert property (ar_take && s_axi_araddr[9:2] < 8'h20
    |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == '0)
    else $error("unmapped read not refused");
  a_label_upper: assert property (ar_take && s_axi_araddr[9:2] inside {[8'h2C:8'h2F]}
    |=> s_axi_rdata[31:3] == '0)
    else $error("label count upper bits not zero");
  a_cell_upper: assert property (ar_take && s_axi_araddr[9:2] inside {[8'h20:8'h2B]}
    |=> s_axi_rdata[31:16] == '0)
    else $error("cell count upper bits not zero");
  a_irq_reset: assert property ($rose(aresetn) |-> !irq)
    else $error("interrupt high out of reset");

  c_slverr: cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
  c_irq: cover property (irq);
  c_read_ok: cover property (s_axi_rvalid && s_axi_rresp == RESP_OKAY);
endmodule // rx_perf_assertions

bind rx_cell_perf_counters rx_perf_assertions u_rx_perf_assertions (.*);

/* File: dv/rx_cell_perf_counters_bench.sv */
`timescale 1ns/100ps
module rx_cell_perf_counters_bench
  import rx_perf_pkg::*;
;
  logic              aclk = 1'b0;
  logic              aresetn = 1'b0;
  logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [DATA_W-1:0] s_axi_wdata = '0;
  logic [3:0]        s_axi_wstrb = 4'hF;
  logic              s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic              s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic              s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  logic [1:0]        s_axi_bresp, s_axi_rresp, r;
  logic [DATA_W-1:0] s_axi_rdata, d;
  logic [NUM_CH-1:0] assigned_cell_stb = '0, idle_cell_stb = '0, hdr_multi_err_stb = '0, label_miss_stb = '0;
  logic [NUM_CH-1:0] cell_sync = '0, cell_delin_lost = '0, loss_of_pointer = '0, path_ais = '0;
  logic              loss_of_signal = 1'b0, loss_of_frame = 1'b0, out_of_frame = 1'b0;
  int                n_errors = 0, checked = 0, cycles = 0;

  rx_cell_perf_counters u_rx_cell_perf_counters (.*);

  always #25 aclk = ~aclk;

  // ****************************************
  // checking and closing
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED %0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // a hang anywhere ends the run as a mismatch
  always @(posedge aclk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      n_errors++;
      close_out();
    end
  end

  // ****************************************
  // bus tasks: ready is looked at on the falling edge, where it is settled
  // ****************************************
  task automatic axi_write(input logic [7:0] idx, input logic [31:0] dat, output logic [1:0] rsp);
    logic aw_t, w_t, b_t;
    int   n;
    n = 0;
    b_t = 1'b0;
    s_axi_awaddr <= {2'h0, idx, 2'h0};
    s_axi_wdata <= dat;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!b_t && n < 50)
    begin
      @(negedge aclk);
      aw_t = s_axi_awvalid && s_axi_awready;
      w_t = s_axi_wvalid && s_axi_wready;
      b_t = s_axi_bvalid;
      rsp = s_axi_bresp;
      @(posedge aclk);
      if (aw_t) s_axi_awvalid <= 1'b0;
      if (w_t) s_axi_wvalid <= 1'b0;
      if (b_t) s_axi_bready <= 1'b0;
      n++;
    end
    // one edge between transfers, so no request signal is driven twice at once
    @(posedge aclk);
    if (!b_t) chk(32'h0, 32'h1, "write timeout");
  endtask

  task automatic axi_read(input logic [7:0] idx, output logic [31:0] dat, output logic [1:0] rsp);
    logic ar_t, r_t;
    int   n;
    n = 0;
    r_t = 1'b0;
    s_axi_araddr <= {2'h0, idx, 2'h0};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!r_t && n < 50)
    begin
      @(negedge aclk);
      ar_t = s_axi_arvalid && s_axi_arready;
      r_t = s_axi_rvalid;
      dat = s_axi_rdata;
      rsp = s_axi_rresp;
      @(posedge aclk);
      if (ar_t) s_axi_arvalid <= 1'b0;
      if (r_t) s_axi_rready <= 1'b0;
      n++;
    end
    @(posedge aclk);
    if (!r_t) chk(32'h0, 32'h1, "read timeout");
  endtask

  task automatic rchk(input logic [7:0] idx, input logic [31:0] exp, input string what);
    logic [31:0] v;
    logic [1:0]  s;
    axi_read(idx, v, s);
    chk(v, exp, what);
    chk({30'h0, s}, {30'h0, RESP_OKAY}, "read response");
  endtask

  task automatic wr_ok(input logic [7:0] idx, input logic [31:0] dat);
    logic [1:0] s;
    axi_write(idx, dat, s);
    chk({30'h0, s}, {30'h0, RESP_OKAY}, "write response");
  endtask

  task automatic irq_chk(input logic e);
    @(negedge aclk);
    chk({31'h0, irq}, {31'h0, e}, "interrupt level");
    @(posedge aclk);
  endtask

  // back-to-back strobe cycles, each one counts once
  task automatic strobe(input int kind, input logic [3:0] m, input int n);
    repeat (n)
    begin
      case (kind)
        0: assigned_cell_stb <= m;
        1: idle_cell_stb <= m;
        2: hdr_multi_err_stb <= m;
        default: label_miss_stb <= m;
      endcase
      @(posedge aclk);
    end
    {assigned_cell_stb, idle_cell_stb, hdr_multi_err_stb, label_miss_stb} <= '0;
    @(posedge aclk);
  endtask

  // ****************************************
  // tests
  // ****************************************
  initial
  begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    irq_chk(1'b0);
    for (int i = 0; i < 16; i++)
      rchk(8'(IDX_ASSIGNED_CH3 + i), (i < 12) ? 32'hFFFC : 32'h6, "reset value");
    $display("test reset_values done");

    wr_ok(IDX_DROPPED_CH0, 32'h0);
    rchk(IDX_DROPPED_CH0, 32'hFFFC, "read-only counter");
    wr_ok(IDX_LABEL_P0, 32'h0);
    rchk(IDX_LABEL_P0, 32'h6, "read-only label count");
    axi_read(8'h10, d, r);
    chk(d, 32'h0, "unmapped read data");
    chk({30'h0, r}, {30'h0, RESP_SLVERR}, "unmapped read response");
    axi_write(8'h10, 32'h1, r);
    chk({30'h0, r}, {30'h0, RESP_SLVERR}, "unmapped write response");
    $display("test read_only done");

    strobe(0, 4'h1, 3);
    rchk(IDX_ASSIGNED_CH0, 32'hFFFF, "assigned ch0 at top");
    rchk(IDX_ROLL_CELL, 32'h0, "no rollover yet");
    strobe(0, 4'h1, 1);
    rchk(IDX_ASSIGNED_CH0, 32'h0, "assigned ch0 wrapped");
    rchk(IDX_ROLL_CELL, 32'h10, "assigned ch0 rollover");
    strobe(0, 4'hE, 4);
    rchk(IDX_ASSIGNED_CH3, 32'h0, "assigned ch3 wrapped");
    rchk(IDX_ROLL_CELL, 32'hF0, "assigned rollovers");
    strobe(1, 4'hF, 4);
    rchk(IDX_IDLE_CH2, 32'h0, "idle ch2 wrapped");
    rchk(IDX_ROLL_CELL, 32'hFF, "idle rollovers");
    $display("test cell_wrap done");

    wr_ok(IDX_ROLL_CELL_EN, 32'h10);
    irq_chk(1'b1);
    wr_ok(IDX_ROLL_CELL_CLR, 32'h10);
    irq_chk(1'b0);
    rchk(IDX_ROLL_CELL, 32'hEF, "partial clear");
    wr_ok(IDX_ROLL_CELL_CLR, 32'hEF);
    rchk(IDX_ROLL_CELL, 32'h0, "full clear");
    // only byte 1 is strobed, so only bits 15..8 get enabled, covering the label rollovers but not the drop rollovers
    s_axi_wstrb <= 4'h2;
    wr_ok(IDX_ROLL_ERR_EN, 32'hFFFF);
    s_axi_wstrb <= 4'hF;
    rchk(IDX_ROLL_ERR_EN, 32'hFF00, "byte strobe enable");
    $display("test interrupt done");

    strobe(2, 4'hF, 1);
    rchk(IDX_DROPPED_CH2, 32'hFFFC, "drop held out of sync");
    cell_sync <= 4'hF;
    cell_delin_lost <= 4'hF;
    strobe(2, 4'hF, 2);
    rchk(IDX_DROPPED_CH0, 32'hFFFC, "drop held while lost");
    cell_delin_lost <= 4'h0;
    strobe(2, 4'hF, 4);
    rchk(IDX_DROPPED_CH1, 32'h0, "drop ch1 wrapped");
    rchk(IDX_ROLL_ERR, 32'h1E, "drop rollovers");
    irq_chk(1'b0);
    $display("test drops done");

    for (int k = 0; k < 6; k++)
    begin
      {path_ais[0], loss_of_pointer[0], cell_delin_lost[0], out_of_frame, loss_of_frame, loss_of_signal} <= 6'h1 << k;
      strobe(3, 4'h1, 1);
      rchk(IDX_LABEL_P0, 32'h6, "label frozen by defect");
    end
    {path_ais[0], loss_of_pointer[0], cell_delin_lost[0], out_of_frame, loss_of_frame, loss_of_signal} <= 6'h0;
    strobe(3, 4'hF, 1);
    rchk(IDX_LABEL_P3, 32'h7, "label at seven");
    strobe(3, 4'hF, 1);
    rchk(IDX_LABEL_P0, 32'h0, "label wrapped");
    rchk(IDX_ROLL_ERR, 32'h1E1E, "label rollovers");
    irq_chk(1'b1);
    $display("test labels done");

    wr_ok(IDX_LINE_MODE, 32'h1);
    strobe(0, 4'hF, 1);
    rchk(IDX_ASSIGNED_CH0, 32'h1, "ch0 counts in concat");
    rchk(IDX_ASSIGNED_CH2, 32'h0, "ch2 held in concat");
    $display("test line_mode done");
    close_out();
  end
endmodule // rx_cell_perf_counters_bench
